// file: tscr_pkg.sv
// Constants for the switch control register block
`default_nettype none
package tscr_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int STREAMS = 32;
  localparam int HALF = 16;
  localparam int MODE_W = 2;
  localparam int CM_AW = 14;
  // Parallel port decode: A15..A14 space, A13..A10 register select
  localparam logic [1:0] SPACE_REG = 2'h1;
  localparam logic [3:0] SEL_CTRL = 4'h0;
  localparam logic [3:0] SEL_ALIGN = 4'h1;
  localparam int SPACE_HI = 15;
  localparam int SPACE_LO = 14;
  localparam int SEL_HI = 13;
  localparam int SEL_LO = 10;
  // Control word fields
  localparam int BIT_SOFT_RESET = 15;
  localparam int BIT_IND_SEL = 14;
  localparam int BIT_IND_POL = 13;
  localparam int BIT_ALL_IND = 12;
  localparam int BIT_ARM = 9;
  localparam int BIT_FILL_HI = 8;
  localparam int BIT_FILL_LO = 7;
  localparam int BIT_FILL_START = 6;
  localparam int BIT_STANDBY = 5;
  localparam int BIT_EVAL_START = 4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  // Frame alignment word fields
  localparam int BIT_EVAL_DONE = 13;
  localparam int OFFSET_W = 13;
  // Timing: fill must finish within two frames
  localparam int FRAME_NS = 125000;
  localparam int CLK_NS = 20;
  localparam int FILL_FRAMES = 2;
  localparam int FILL_LIMIT_CYC = (FILL_FRAMES * FRAME_NS) / CLK_NS;
endpackage
`default_nettype wire

// file: tscr_fill_seq.sv
// Connection memory mode block fill sequencer
`default_nettype none
module tscr_fill_seq #(
  parameter int CM_DEPTH = 16384,
  parameter int LANES = 2
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clear,
  // Command
  input wire logic start,
  input wire logic [tscr_pkg::MODE_W-1:0] value,
  // Memory side, LANES consecutive words per strobe
  output logic fill_we,
  output logic [tscr_pkg::CM_AW-1:0] fill_base,
  output logic [tscr_pkg::MODE_W-1:0] fill_value,
  output logic busy,
  output logic done
);
  localparam logic [tscr_pkg::CM_AW-1:0] STEP = tscr_pkg::CM_AW'(LANES);
  localparam logic [tscr_pkg::CM_AW-1:0] LAST = tscr_pkg::CM_AW'(CM_DEPTH - LANES);
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [tscr_pkg::CM_AW-1:0] base_reg, base_next;
  logic [tscr_pkg::MODE_W-1:0] val_reg, val_next;

  always_comb
  begin
    busy_next = busy_reg;
    done_next = 1'b0;
    base_next = base_reg;
    val_next = val_reg;
    if (clear)
    begin
      busy_next = 1'b0;
      base_next = '0;
    end
    else if (busy_reg)
    begin
      base_next = base_reg + STEP;
      if (base_reg == LAST)
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
        base_next = '0;
      end
    end
    else if (start)
    begin
      busy_next = 1'b1;
      val_next = value;
      base_next = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      base_reg <= '0;
      val_reg <= '0;
    end
    else
    begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      base_reg <= base_next;
      val_reg <= val_next;
    end
  end

  assign fill_we = busy_reg;
  assign fill_base = base_reg;
  assign fill_value = val_reg;
  assign busy = busy_reg;
  assign done = done_reg;
endmodule // tscr_fill_seq
`default_nettype wire

// file: tscr_control.sv
// Switch control register with output pin steering and block fill
`default_nettype none
module tscr_control #(
  parameter int CM_DEPTH = 16384,
  parameter int FILL_LANES = 2,
  parameter int FILL_LIMIT = tscr_pkg::FILL_LIMIT_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Parallel host port
  input wire logic cpu_cs_n,
  input wire logic cpu_rw,
  input wire logic [tscr_pkg::ADDR_W-1:0] cpu_addr,
  input wire logic [tscr_pkg::DATA_W-1:0] cpu_data_in,
  output logic [tscr_pkg::DATA_W-1:0] cpu_data_out,
  output logic cpu_data_oe_n,
  // Device wide reset to the rest of the switch
  output logic soft_reset_pulse,
  // Serial datapath side
  input wire logic ode_pin,
  input wire logic [tscr_pkg::STREAMS-1:0] stream_data,
  input wire logic [tscr_pkg::STREAMS-1:0] stream_chan_hiz,
  output logic [tscr_pkg::STREAMS-1:0] serial_out_streams,
  output logic [tscr_pkg::STREAMS-1:0] serial_out_oe_n,
  // Connection memory block fill
  output logic cm_fill_we,
  output logic [tscr_pkg::CM_AW-1:0] cm_fill_base,
  output logic [tscr_pkg::MODE_W-1:0] cm_fill_value,
  // Frame offset evaluation
  output logic frame_eval_start,
  input wire logic frame_eval_measured,
  input wire logic [tscr_pkg::OFFSET_W-1:0] frame_offset_value
);
  function automatic logic reg_hit(input logic [tscr_pkg::ADDR_W-1:0] a, input logic [3:0] sel);
    reg_hit = (a[tscr_pkg::SPACE_HI:tscr_pkg::SPACE_LO] == tscr_pkg::SPACE_REG)
      && (a[tscr_pkg::SEL_HI:tscr_pkg::SEL_LO] == sel);
  endfunction

  logic wr_ctrl, rd_ctrl, rd_align;
  logic soft_reset_reg, soft_reset_next;
  logic ind_sel_reg, ind_sel_next;
  logic ind_pol_reg, ind_pol_next;
  logic all_ind_reg, all_ind_next;
  logic arm_reg, arm_next;
  logic [tscr_pkg::MODE_W-1:0] fill_val_reg, fill_val_next;
  logic fill_start_reg, fill_start_next;
  logic standby_reg, standby_next;
  logic eval_reg, eval_next;
  logic done_reg, done_next;
  logic [tscr_pkg::DATA_W-1:0] ctrl_word, align_word;
  logic [tscr_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic rd_en_reg, rd_en_next;
  logic fill_go, fill_busy, fill_done;
  logic [tscr_pkg::STREAMS-1:0] active;
  logic [tscr_pkg::STREAMS-1:0] pin_reg, pin_next;
  logic [tscr_pkg::STREAMS-1:0] oe_n_reg, oe_n_next;

  assign wr_ctrl = !cpu_cs_n && !cpu_rw && reg_hit(cpu_addr, tscr_pkg::SEL_CTRL);
  assign rd_ctrl = !cpu_cs_n && cpu_rw && reg_hit(cpu_addr, tscr_pkg::SEL_CTRL);
  assign rd_align = !cpu_cs_n && cpu_rw && reg_hit(cpu_addr, tscr_pkg::SEL_ALIGN);
  // Fill launches only on the cycle the start bit is first accepted
  assign fill_go = fill_start_next && !fill_start_reg && !soft_reset_reg;

  // Control word: unused bits are not stored and read back zero
  always_comb
  begin
    ctrl_word = tscr_pkg::CTRL_RESET;
    ctrl_word[tscr_pkg::BIT_SOFT_RESET] = soft_reset_reg;
    ctrl_word[tscr_pkg::BIT_IND_SEL] = ind_sel_reg;
    ctrl_word[tscr_pkg::BIT_IND_POL] = ind_pol_reg;
    ctrl_word[tscr_pkg::BIT_ALL_IND] = all_ind_reg;
    ctrl_word[tscr_pkg::BIT_ARM] = arm_reg;
    ctrl_word[tscr_pkg::BIT_FILL_HI:tscr_pkg::BIT_FILL_LO] = fill_val_reg;
    ctrl_word[tscr_pkg::BIT_FILL_START] = fill_start_reg;
    ctrl_word[tscr_pkg::BIT_STANDBY] = standby_reg;
    ctrl_word[tscr_pkg::BIT_EVAL_START] = eval_reg;
    align_word = '0;
    align_word[tscr_pkg::BIT_EVAL_DONE] = done_reg;
    align_word[tscr_pkg::OFFSET_W-1:0] = frame_offset_value;
  end

  always_comb
  begin
    soft_reset_next = 1'b0;
    ind_sel_next = ind_sel_reg;
    ind_pol_next = ind_pol_reg;
    all_ind_next = all_ind_reg;
    arm_next = arm_reg;
    fill_val_next = fill_val_reg;
    fill_start_next = fill_start_reg;
    standby_next = standby_reg;
    eval_next = eval_reg;
    done_next = done_reg;
    if (fill_done)
      fill_start_next = 1'b0;
    if (frame_eval_measured && eval_reg)
      done_next = 1'b1;
    if (soft_reset_reg)
    begin
      // Whole register returns to its reset state, as the pin would do
      ind_sel_next = 1'b0;
      ind_pol_next = 1'b0;
      all_ind_next = 1'b0;
      arm_next = 1'b0;
      fill_val_next = '0;
      fill_start_next = 1'b0;
      standby_next = 1'b0;
      eval_next = 1'b0;
      done_next = 1'b0;
    end
    else if (wr_ctrl)
    begin
      soft_reset_next = cpu_data_in[tscr_pkg::BIT_SOFT_RESET];
      ind_sel_next = cpu_data_in[tscr_pkg::BIT_IND_SEL];
      ind_pol_next = cpu_data_in[tscr_pkg::BIT_IND_POL];
      all_ind_next = cpu_data_in[tscr_pkg::BIT_ALL_IND];
      arm_next = cpu_data_in[tscr_pkg::BIT_ARM];
      fill_val_next = cpu_data_in[tscr_pkg::BIT_FILL_HI:tscr_pkg::BIT_FILL_LO];
      // A start written without the arm bit in the same word is dropped
      if (cpu_data_in[tscr_pkg::BIT_FILL_START] && cpu_data_in[tscr_pkg::BIT_ARM])
        fill_start_next = 1'b1;
      else if (!fill_busy)
        fill_start_next = 1'b0;
      standby_next = cpu_data_in[tscr_pkg::BIT_STANDBY];
      eval_next = cpu_data_in[tscr_pkg::BIT_EVAL_START];
      // Falling start clears done; a measurement in that cycle is lost by design
      if (eval_reg && !cpu_data_in[tscr_pkg::BIT_EVAL_START])
        done_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      soft_reset_reg <= 1'b0;
      ind_sel_reg <= 1'b0;
      ind_pol_reg <= 1'b0;
      all_ind_reg <= 1'b0;
      arm_reg <= 1'b0;
      fill_val_reg <= '0;
      fill_start_reg <= 1'b0;
      standby_reg <= 1'b0;
      eval_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      soft_reset_reg <= soft_reset_next;
      ind_sel_reg <= ind_sel_next;
      ind_pol_reg <= ind_pol_next;
      all_ind_reg <= all_ind_next;
      arm_reg <= arm_next;
      fill_val_reg <= fill_val_next;
      fill_start_reg <= fill_start_next;
      standby_reg <= standby_next;
      eval_reg <= eval_next;
      done_reg <= done_next;
    end
  end

  // Read data is registered; the bus driver turns on one cycle after the strobe
  always_comb
  begin
    rd_en_next = rd_ctrl || rd_align;
    rdata_next = rdata_reg;
    if (rd_ctrl)
      rdata_next = ctrl_word;
    else if (rd_align)
      rdata_next = align_word;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_en_reg <= 1'b0;
      rdata_reg <= '0;
    end
    else
    begin
      rd_en_reg <= rd_en_next;
      rdata_reg <= rdata_next;
    end
  end

  assign cpu_data_out = rdata_reg;
  assign cpu_data_oe_n = !rd_en_reg;
  assign soft_reset_pulse = soft_reset_reg;
  assign frame_eval_start = eval_reg;

  tscr_fill_seq #(
    .CM_DEPTH(CM_DEPTH),
    .LANES(FILL_LANES)
  ) u_fill (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clear(soft_reset_reg),
    .start(fill_go),
    .value(fill_val_next),
    .fill_we(cm_fill_we),
    .fill_base(cm_fill_base),
    .fill_value(cm_fill_value),
    .busy(fill_busy),
    .done(fill_done)
  );

  // Pin steering per stream
  genvar gi;
  generate
    for (gi = 0; gi < tscr_pkg::STREAMS; gi++)
    begin : g_pin
      // Mode eleven wins over drive pin and standby
      assign active[gi] = !stream_chan_hiz[gi] && (ode_pin || standby_reg);
      always_comb
      begin
        if (all_ind_reg)
        begin
          pin_next[gi] = ind_pol_reg ? active[gi] : !active[gi];
          oe_n_next[gi] = 1'b0;
        end
        else if (ind_sel_reg && gi >= tscr_pkg::HALF)
        begin
          // Index wraps so upper pins read active bits 15..0 and never form a select above bit 31
          pin_next[gi] = ind_pol_reg ? active[(gi + tscr_pkg::HALF) % tscr_pkg::STREAMS]
            : !active[(gi + tscr_pkg::HALF) % tscr_pkg::STREAMS];
          oe_n_next[gi] = 1'b0;
        end
        else
        begin
          pin_next[gi] = stream_data[gi];
          oe_n_next[gi] = !active[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_reg <= '0;
      oe_n_reg <= '1;
    end
    else
    begin
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign serial_out_streams = pin_reg;
  assign serial_out_oe_n = oe_n_reg;

  // Helper: cycles spent on a fill
  logic [31:0] fill_cnt;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      fill_cnt <= '0;
    else
      fill_cnt <= fill_busy ? fill_cnt + 32'd1 : '0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_soft_reset_clears: assert property (soft_reset_reg |=> ctrl_word == tscr_pkg::CTRL_RESET)
    else $error("soft reset left control bits set");
  a_fill_needs_arm: assert property (fill_go |-> arm_next)
    else $error("block fill launched without arm");
  a_fill_in_time: assert property (fill_cnt < FILL_LIMIT)
    else $error("block fill exceeded two frames");
  a_start_self_clear: assert property (fill_done && !wr_ctrl |=> !fill_start_reg)
    else $error("fill start not cleared on completion");
  a_standby_float: assert property (!ode_pin && !standby_reg && !all_ind_reg && !ind_sel_reg
    |=> serial_out_oe_n == '1)
    else $error("outputs driven in standby");
  a_chan_hiz: assert property (stream_chan_hiz[0] && !all_ind_reg |=> serial_out_oe_n[0])
    else $error("mode eleven channel driven");
  a_upper_ind: assert property (ind_sel_reg && !all_ind_reg && ind_pol_reg
    |=> serial_out_oe_n[31:16] == '0 && serial_out_streams[31:16] == $past(active[15:0]))
    else $error("upper pins not indicating");
  a_all_ind: assert property (all_ind_reg && !ind_pol_reg |=> serial_out_streams == ~$past(active))
    else $error("all-lines indicator wrong");
  a_drive_on: assert property ((ode_pin || standby_reg) && !stream_chan_hiz[0] && !all_ind_reg
    |=> !serial_out_oe_n[0])
    else $error("stream not driven when enabled");
  a_done_clear: assert property ($fell(eval_reg) |-> !done_reg)
    else $error("evaluation done not cleared");
endmodule // tscr_control
`default_nettype wire

// file: tscr_host_model.sv
// Host model driving the parallel register port
`default_nettype none
module tscr_host_model (
  // Clock
  input wire logic core_clk,
  // Parallel port
  output logic cpu_cs_n,
  output logic cpu_rw,
  output logic [tscr_pkg::ADDR_W-1:0] cpu_addr,
  output logic [tscr_pkg::DATA_W-1:0] cpu_data_in,
  input wire logic [tscr_pkg::DATA_W-1:0] cpu_data_out,
  input wire logic cpu_data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cpu_cs_n = 1'b1;
    cpu_rw = 1'b1;
    cpu_addr = 16'h0000;
    cpu_data_in = 16'h0000;
  end
  // Released lines flip so a stale value never passes for a fresh one
  task automatic release_bus();
    cpu_cs_n <= 1'b1;
    cpu_rw <= 1'b1;
    cpu_addr <= ~cpu_addr;
    cpu_data_in <= ~cpu_data_in;
  endtask
  // Callers keep unused bits and soft reset clear outside reset tests
  // Fill value, arm and start go out in one word
  task automatic write(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    cpu_cs_n <= 1'b0;
    cpu_rw <= 1'b0;
    cpu_addr <= a;
    cpu_data_in <= d;
    @(posedge core_clk);
    release_bus();
  endtask
  task automatic read(input logic [15:0] a, output logic [15:0] d, output logic oe_n);
    @(posedge core_clk);
    cpu_cs_n <= 1'b0;
    cpu_rw <= 1'b1;
    cpu_addr <= a;
    @(posedge core_clk);
    #1;
    d = cpu_data_out;
    oe_n = cpu_data_oe_n;
    @(posedge core_clk);
    release_bus();
  endtask
endmodule // tscr_host_model
`default_nettype wire

// file: tscr_control_test.sv
// Self-checking testbench for the switch control register
`default_nettype none
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module tscr_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  localparam logic [15:0] CTRL_A = 16'h4000;
  localparam logic [15:0] ALIGN_A = 16'h4400;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_cs_n, cpu_rw, cpu_data_oe_n, soft_reset_pulse, ode_pin, cm_fill_we;
  logic frame_eval_start, frame_eval_measured;
  logic [15:0] cpu_addr, cpu_data_in, cpu_data_out;
  logic [31:0] stream_data, stream_chan_hiz, serial_out_streams, serial_out_oe_n;
  logic [13:0] cm_fill_base;
  logic [1:0] cm_fill_value;
  logic [12:0] frame_offset_value;
  logic [15:0] rd;
  logic oe;
  int mismatches = 0;
  int total_checks = 0;
  int fill_cnt = 0;
  int fill_err = 0;
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  tscr_host_model host (.core_clk(core_clk), .cpu_cs_n(cpu_cs_n), .cpu_rw(cpu_rw), .cpu_addr(cpu_addr),
    .cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out), .cpu_data_oe_n(cpu_data_oe_n));
  tscr_control #(.CM_DEPTH(DEPTH), .FILL_LANES(2)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .cpu_cs_n(cpu_cs_n), .cpu_rw(cpu_rw), .cpu_addr(cpu_addr), .cpu_data_in(cpu_data_in),
    .cpu_data_out(cpu_data_out), .cpu_data_oe_n(cpu_data_oe_n), .soft_reset_pulse(soft_reset_pulse),
    .ode_pin(ode_pin), .stream_data(stream_data), .stream_chan_hiz(stream_chan_hiz),
    .serial_out_streams(serial_out_streams), .serial_out_oe_n(serial_out_oe_n), .cm_fill_we(cm_fill_we),
    .cm_fill_base(cm_fill_base), .cm_fill_value(cm_fill_value), .frame_eval_start(frame_eval_start),
    .frame_eval_measured(frame_eval_measured), .frame_offset_value(frame_offset_value));
  // Strobe count and address walk of a block fill, value 2 expected
  always @(posedge core_clk)
  begin
    if (cm_fill_we === 1'b1)
    begin
      if (cm_fill_base !== 14'(2 * fill_cnt) || cm_fill_value !== 2'h2)
        fill_err <= fill_err + 1;
      fill_cnt <= fill_cnt + 1;
    end
  end
  function automatic logic [63:0] exp_pins(logic [15:0] c, logic o, logic [31:0] d, logic [31:0] h);
    logic [31:0] act;
    logic [31:0] ind;
    logic [31:0] pin;
    logic [31:0] oen;
    act = ~h & {32{o | c[tscr_pkg::BIT_STANDBY]}};
    ind = c[tscr_pkg::BIT_IND_POL] ? act : ~act;
    pin = d;
    oen = ~act;
    if (c[tscr_pkg::BIT_ALL_IND])
    begin
      pin = ind;
      oen = 32'h0000_0000;
    end
    else if (c[tscr_pkg::BIT_IND_SEL])
    begin
      pin[31:16] = ind[15:0];
      oen[31:16] = 16'h0000;
    end
    return {oen, pin};
  endfunction
  task automatic set_check(logic [15:0] c, logic o, logic [31:0] d, logic [31:0] h);
    @(posedge core_clk);
    ode_pin <= o;
    stream_data <= d;
    stream_chan_hiz <= h;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("pins", exp_pins(c, o, d, h), {serial_out_oe_n, serial_out_streams})
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_reset();
    host.read(CTRL_A, rd, oe);
    `CHK("control after reset", 16'h0000, rd)
    host.read(16'h2000, rd, oe);
    `CHK("unmapped drive", 1'b1, oe)
  endtask
  // Bit 12 with bit 14 checks the override; standby in both plain and indicator modes
  task automatic t_pins();
    logic [15:0] tab [8] = '{16'h0000, 16'h0020, 16'h4000, 16'h6000, 16'h1000, 16'h3000, 16'h5000, 16'h7020};
    for (int m = 0; m < 8; m++)
    begin
      host.write(CTRL_A, tab[m]);
      for (int k = 0; k < 4; k++)
        set_check(tab[m], k[0], 32'hA5C3_0F96, k[1] ? 32'h00FF_FF01 : 32'h0);
    end
  endtask
  task automatic t_fill();
    fill_cnt = 0;
    fill_err = 0;
    host.write(CTRL_A, 16'h0040);
    repeat (20) @(posedge core_clk);
    `CHK("fill without arm", 0, fill_cnt)
    host.write(CTRL_A, 16'h0340);
    host.read(CTRL_A, rd, oe);
    `CHK("start bit during fill", 1'b1, rd[6])
    for (int i = 0; i < 20 && rd[6] !== 1'b0; i++)
      host.read(CTRL_A, rd, oe);
    `CHK("start bit after fill", 1'b0, rd[6])
    `CHK("fill strobes", DEPTH / 2, fill_cnt)
    `CHK("fill walk errors", 0, fill_err)
  endtask
  task automatic t_eval();
    host.write(CTRL_A, 16'h0010);
    @(posedge core_clk);
    #1;
    `CHK("eval start", 1'b1, frame_eval_start)
    @(posedge core_clk);
    frame_eval_measured <= 1'b1;
    frame_offset_value <= 13'h0ABC;
    @(posedge core_clk);
    frame_eval_measured <= 1'b0;
    host.read(ALIGN_A, rd, oe);
    `CHK("align done", 16'h2ABC, rd)
    host.write(CTRL_A, 16'h0000);
    host.read(ALIGN_A, rd, oe);
    `CHK("align cleared", 16'h0ABC, rd)
  endtask
  task automatic t_soft();
    logic seen;
    seen = 1'b0;
    host.write(CTRL_A, 16'h3C0F);
    host.read(CTRL_A, rd, oe);
    `CHK("unused bits", 16'h3000, rd)
    host.write(CTRL_A, 16'h8000);
    // The pulse stands only in the cycle right after the write edge
    for (int i = 0; i < 4; i++)
    begin
      #1;
      if (soft_reset_pulse === 1'b1)
        seen = 1'b1;
      @(posedge core_clk);
    end
    `CHK("soft reset pulse", 1'b1, seen)
    host.read(CTRL_A, rd, oe);
    `CHK("control after soft reset", 16'h0000, rd)
    set_check(16'h0000, 1'b0, 32'h1234_5678, 32'h0);
  endtask
  // Hang guard: a stuck run still reaches the verdict
  initial
  begin
    #1ms;
    mismatches++;
    summarize();
  end
  initial
  begin
    ode_pin = 1'b0;
    stream_data = 32'h0;
    stream_chan_hiz = 32'h0;
    frame_eval_measured = 1'b0;
    frame_offset_value = 13'h0000;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_pins();
    t_fill();
    t_eval();
    t_soft();
    summarize();
  end
endmodule // tscr_control_test
`default_nettype wire
